// ==== psa_prog_space_addr.sv ====
// program space address generation and software stack checking
// assumes single clock, inputs synchronous, pipeline gives one op a cycle
`timescale 1ns/100ps
`include "psa_defs.svh"

// Summary of operation
// - pointer holds next free word, grows upward
// - push writes then increments; pop decrements first
// - call push clears pushed program counter top bit
// - exception push puts status low byte above
// - limit bit zero reads zero once the limit is written
// - limit register has no reset value
// - every stack pointer address checked against limit
// - push at limit passes, next push traps
// - pointer below 0800h raises underflow trap
// - table address is page over effective address
// - page bit seven selects configuration space
// - visibility address top bit always zero
// - visibility bit 15 comes from page bit 0
// - fetch and visibility address bit zero cleared
// - table accesses allow odd byte addresses
// - table reads allowed in configuration space
// - visibility access read only, low word only
// - table ops reach upper byte and low word
// - visibility needs enable bit and address bit 15
// - table writes to configuration space rejected
// - visibility suspended while table op runs
module psa_prog_space_addr
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [15:0] effectiveAddress,
    input wire logic [7:0] tablePageReg,
    input wire logic [7:0] visibilityPageReg,
    input wire logic [15:0] coreControlReg,
    input wire logic tableReadOp,
    input wire logic tableWriteOp,
    input wire logic tableUpperSel,
    input wire logic dataRead,
    input wire logic fetchEn,
    input wire logic [22:0] programCounter,
    input wire logic stackLimitWrite,
    input wire logic [15:0] stackLimitData,
    input wire logic stackPointerWrite,
    input wire logic [15:0] stackPointerData,
    input wire logic [1:0] stackOp,
    input wire logic [15:0] stackPushData,
    input wire logic callPush,
    input wire logic exceptionPush,
    input wire logic [7:0] statusLowByte,
    output logic [23:0] progAddr,
    output logic progAddrValid,
    output logic progWriteEn,
    output logic upperByteSel,
    output logic configSpace,
    output logic visibilityLowWordOnly,
    output logic [15:0] stackPointer,
    output logic [15:0] stackLimit,
    output logic [15:0] stackAddr,
    output logic [15:0] stackWriteData,
    output logic stackWriteEn,
    output logic stackReadEn,
    output logic stackOverflowTrap,
    output logic stackUnderflowTrap,
    output logic tableWriteReject
);
    psa_pkg::psa_state_type state;
    psa_pkg::psa_state_type next_state;
    psa_pkg::psa_stack_op_type op;
    logic tableBusy;
    logic visActive;
    logic [15:0] checkAddr;
    logic [15:0] spAfterPop;
    logic visFlag;

    // ----------------------------------------
    // address generation and stack checks
    // ----------------------------------------
    always_comb
    begin
        next_state = state;
        op = psa_pkg::psa_stack_op_type'(stackOp);
        tableBusy = tableReadOp | tableWriteOp;
        visActive = coreControlReg[`PSA_VIS_EN_BIT] &
            effectiveAddress[`PSA_EA_MSB] & dataRead & ~tableBusy;
        spAfterPop = state.stackPointer - `PSA_WORD_STEP;
        checkAddr = state.stackPointer;
        next_state.progAddrValid = 1'b0;
        next_state.progWriteEn = 1'b0;
        next_state.upperByteSel = 1'b0;
        next_state.configSpace = 1'b0;
        next_state.tableWriteReject = 1'b0;
        next_state.stackWriteEn = 1'b0;
        next_state.stackReadEn = 1'b0;
        next_state.stackOverflowTrap = 1'b0;
        next_state.stackUnderflowTrap = 1'b0;

        if (stackLimitWrite)
        begin
            next_state.stackLimit = {stackLimitData[15:1], 1'b0};
        end

        if (tableBusy)
        begin
            // full byte address, page above effective address
            next_state.progAddr = {tablePageReg, effectiveAddress};
            next_state.configSpace = tablePageReg[`PSA_CFG_BIT];
            next_state.upperByteSel = tableUpperSel;
            if (tableWriteOp && tablePageReg[`PSA_CFG_BIT])
            begin
                next_state.tableWriteReject = 1'b1;
            end
            else
            begin
                next_state.progAddrValid = 1'b1;
                next_state.progWriteEn = tableWriteOp;
            end
        end
        else if (visActive)
        begin
            next_state.progAddr = {`PSA_PA_ZERO_MSB, visibilityPageReg,
                effectiveAddress[14:1], 1'b0};
            next_state.progAddrValid = 1'b1;
            next_state.progWriteEn = 1'b0;
        end
        else if (fetchEn)
        begin
            next_state.progAddr = {`PSA_PA_ZERO_MSB, programCounter[22:1],
                1'b0};
            next_state.progAddrValid = 1'b1;
        end

        if (stackPointerWrite)
        begin
            next_state.stackPointer = {stackPointerData[15:1], 1'b0};
        end
        else if (op == psa_pkg::STK_PUSH)
        begin
            checkAddr = state.stackPointer;
            next_state.stackAddr = state.stackPointer;
            next_state.stackWriteEn = 1'b1;
            if (exceptionPush)
            begin
                next_state.stackWriteData = {statusLowByte,
                    stackPushData[7:0]};
            end
            else if (callPush)
            begin
                next_state.stackWriteData = {1'b0,
                    stackPushData[`PSA_PC_MSB-1:0]};
            end
            else
            begin
                next_state.stackWriteData = stackPushData;
            end
            next_state.stackPointer = state.stackPointer +
                `PSA_WORD_STEP;
            // pointer equal to limit still allowed
            next_state.stackOverflowTrap =
                checkAddr > state.stackLimit;
            next_state.stackUnderflowTrap =
                checkAddr < `PSA_STACK_FLOOR;
        end
        else if (op == psa_pkg::STK_POP)
        begin
            checkAddr = spAfterPop;
            next_state.stackAddr = spAfterPop;
            next_state.stackReadEn = 1'b1;
            next_state.stackPointer = spAfterPop;
            next_state.stackOverflowTrap =
                checkAddr > state.stackLimit;
            next_state.stackUnderflowTrap =
                checkAddr < `PSA_STACK_FLOOR;
        end
    end

    // ----------------------------------------
    // state register
    // ----------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            // limit left as is through reset
            state <= '{stackPointer: `PSA_STACK_FLOOR,
                stackLimit: state.stackLimit, default: '0};
        end
        else
        begin
            state <= next_state;
        end
    end

    // ----------------------------------------
    // visibility flag for the read port
    // ----------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            visFlag <= 1'b0;
        end
        else
        begin
            visFlag <= visActive;
        end
    end

    assign progAddr = state.progAddr;
    assign progAddrValid = state.progAddrValid;
    assign progWriteEn = state.progWriteEn;
    assign upperByteSel = state.upperByteSel;
    assign configSpace = state.configSpace;
    assign visibilityLowWordOnly = visFlag;
    assign stackPointer = state.stackPointer;
    assign stackLimit = state.stackLimit;
    assign stackAddr = state.stackAddr;
    assign stackWriteData = state.stackWriteData;
    assign stackWriteEn = state.stackWriteEn;
    assign stackReadEn = state.stackReadEn;
    assign stackOverflowTrap = state.stackOverflowTrap;
    assign stackUnderflowTrap = state.stackUnderflowTrap;
    assign tableWriteReject = state.tableWriteReject;
endmodule

// ==== psa_defs.svh ====
// constants for the program space address and stack check block
// assumes a 16-bit data path and a 24-bit program address
`ifndef PSA_DEFS_SVH
`define PSA_DEFS_SVH
// ----------------------------------------
// stack bounds, widths and bit positions
// ----------------------------------------
`define PSA_STACK_FLOOR 16'h0800
`define PSA_WORD_STEP 16'h0002
`define PSA_PC_MSB 15
`define PSA_VIS_EN_BIT 2
`define PSA_CFG_BIT 7
`define PSA_EA_MSB 15
`define PSA_PA_ZERO_MSB 1'h0
`endif

// ==== psa_pkg.sv ====
// types for the program space address and stack check block
// assumes psa_defs.svh is on the include path
package psa_pkg;
    // ----------------------------------------
    // stack operation kinds
    // ----------------------------------------
    typedef enum logic [1:0]
    {
        STK_IDLE = 2'h0,
        STK_PUSH = 2'h1,
        STK_POP = 2'h3
    } psa_stack_op_type;

    typedef struct packed
    {
        logic [15:0] stackPointer;
        logic [15:0] stackLimit;
        logic [23:0] progAddr;
        logic progAddrValid;
        logic progWriteEn;
        logic upperByteSel;
        logic configSpace;
        logic [15:0] stackAddr;
        logic [15:0] stackWriteData;
        logic stackWriteEn;
        logic stackReadEn;
        logic stackOverflowTrap;
        logic stackUnderflowTrap;
        logic tableWriteReject;
    } psa_state_type;
endpackage

// ==== psa_stack_mem.sv ====
// stack word memory model on the far side of the stack port
// assumes pushes and pops arrive as one-cycle strobes
`timescale 1ns/100ps
module psa_stack_mem
(
    input wire logic clk,
    input wire logic [15:0] stackAddr,
    input wire logic [15:0] stackWriteData,
    input wire logic stackWriteEn,
    output logic [15:0] readData
);
    logic [15:0] mem [0:255];

    always_ff @(posedge clk)
        if (stackWriteEn)
            mem[stackAddr[8:1]] <= stackWriteData;

    assign readData = mem[stackAddr[8:1]];
endmodule

// ==== psa_chk.sv ====
// port checker for the program space address block
// assumes a bind from the testbench top
`timescale 1ns/100ps
module psa_chk
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [15:0] effectiveAddress,
    input wire logic [7:0] tablePageReg,
    input wire logic [7:0] visibilityPageReg,
    input wire logic [15:0] coreControlReg,
    input wire logic tableReadOp,
    input wire logic tableWriteOp,
    input wire logic dataRead,
    input wire logic stackLimitWrite,
    input wire logic stackPointerWrite,
    input wire logic [1:0] stackOp,
    input wire logic callPush,
    input wire logic [23:0] progAddr,
    input wire logic progAddrValid,
    input wire logic progWriteEn,
    input wire logic visibilityLowWordOnly,
    input wire logic [15:0] stackPointer,
    input wire logic [15:0] stackLimit,
    input wire logic [15:0] stackAddr,
    input wire logic [15:0] stackWriteData,
    input wire logic stackWriteEn,
    input wire logic stackReadEn,
    input wire logic stackOverflowTrap,
    input wire logic stackUnderflowTrap,
    input wire logic tableWriteReject
);
    logic push;
    logic vis;
    logic [23:0] visAddr;

    assign push = stackOp == 2'h1 && !stackPointerWrite;
    assign vis = dataRead && coreControlReg[2] && effectiveAddress[15]
        && !tableReadOp && !tableWriteOp;
    assign visAddr = {1'h0, visibilityPageReg, effectiveAddress[14:1], 1'h0};

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_push_write: assert property (push |=> stackWriteEn
        && stackAddr == $past(stackPointer)) else $error("push addr");
    a_push_step: assert property (push |=>
        stackPointer == $past(stackPointer) + 16'h0002) else $error("push sp");
    a_pop_first: assert property (stackOp == 2'h3 && !stackPointerWrite
        |=> stackReadEn && stackAddr == $past(stackPointer) - 16'h0002)
        else $error("pop addr");
    a_limit_trap: assert property (push |=> stackOverflowTrap ==
        ($past(stackPointer) > $past(stackLimit))) else $error("overflow");
    a_floor_trap: assert property (push && stackPointer < 16'h0800
        |=> stackUnderflowTrap) else $error("underflow");
    a_limit_even: assert property (stackLimitWrite |=>
        !stackLimit[0]) else $error("limit bit0");
    a_table_addr: assert property (tableReadOp |=> progAddrValid
        && progAddr == {$past(tablePageReg), $past(effectiveAddress)})
        else $error("table addr");
    a_cfg_reject: assert property (tableWriteOp && tablePageReg[7]
        |=> tableWriteReject && !progAddrValid) else $error("cfg write");
    a_vis_addr: assert property (vis |=> progAddrValid
        && progAddr == $past(visAddr)) else $error("vis addr");
    a_call_clear: assert property (push && callPush |=>
        !stackWriteData[15]) else $error("call msb");
    a_vis_user: assert property (vis |=> !progAddr[23]
        && !progAddr[0]) else $error("vis space");
    a_vis_rdonly: assert property (vis |=> !progWriteEn
        && visibilityLowWordOnly) else $error("vis write");
    a_trap_pulse: assert property (stackOverflowTrap |=>
        !stackOverflowTrap || $past(push)) else $error("trap pulse");
endmodule

// ==== tb_top.sv ====
// self-checking bench for the program space address block
// assumes inputs driven on the falling clock edge
`timescale 1ns/100ps
module tb_top;
    logic clk, rst_n, tableReadOp, tableWriteOp, tableUpperSel, dataRead;
    logic fetchEn, stackLimitWrite, stackPointerWrite, callPush;
    logic exceptionPush, progAddrValid, progWriteEn, upperByteSel;
    logic configSpace, visibilityLowWordOnly, stackWriteEn, stackReadEn;
    logic stackOverflowTrap, stackUnderflowTrap, tableWriteReject;
    logic [1:0] stackOp;
    logic [7:0] tablePageReg, visibilityPageReg, statusLowByte;
    logic [15:0] effectiveAddress, coreControlReg, stackLimitData;
    logic [15:0] stackPointerData, stackPushData, stackPointer, stackLimit;
    logic [15:0] stackAddr, stackWriteData, readData;
    logic [22:0] programCounter;
    logic [23:0] progAddr;
    int errCount = 0;
    int testsRun = 0;

    psa_prog_space_addr u_psa_prog_space_addr (.*);
    psa_stack_mem u_psa_stack_mem (.*);

    initial
    begin
        clk = 0;
        forever #4 clk = ~clk;
    end

    task automatic chk(string name, logic [23:0] exp, logic [23:0] got);
        testsRun++;
        if (got !== exp)
        begin
            errCount++;
            $display("[ERR] %s exp %h got %h", name, exp, got);
        end
    endtask

    task automatic step;
        @(negedge clk);
        {tableReadOp, tableWriteOp, dataRead, fetchEn, stackOp} = '0;
        {stackLimitWrite, stackPointerWrite, callPush, exceptionPush} = '0;
    endtask

    task automatic push(logic [15:0] d, logic c, logic e);
        stackPushData = d;
        callPush = c;
        exceptionPush = e;
        stackOp = 2'h1;
        step();
    endtask

    task automatic t_stack;
        stackLimitData = 16'h0805;
        stackLimitWrite = 1;
        step();
        chk("limit", 16'h0804, stackLimit);
        step(); // idle cycle after limit write
        for (int i = 0; i < 3; i++)
        begin
            push(16'h1000 + i, 0, 0);
            chk("paddr", 16'h0800 + 2 * i, stackAddr);
            chk("sp", 16'h0802 + 2 * i, stackPointer);
        end
        stackOp = 2'h3;
        step();
        chk("pop", 16'h0804, stackAddr);
        chk("data", 16'h1002, readData);
        push(16'h1111, 0, 0);
        chk("equal", 0, stackOverflowTrap);
        push(16'h2222, 0, 0);
        chk("over", 1, stackOverflowTrap);
        step();
        chk("pulse", 0, stackOverflowTrap);
        stackPointerData = 16'h07fe;
        stackPointerWrite = 1;
        step();
        push(16'hffff, 1, 0);
        chk("under", 1, stackUnderflowTrap);
        chk("call", 16'h7fff, stackWriteData);
        statusLowByte = 8'ha5;
        push(16'h1234, 0, 1);
        chk("exc", 16'ha534, stackWriteData);
    endtask

    task automatic t_table;
        effectiveAddress = 16'hb457;
        coreControlReg = 16'h0004;
        for (int i = 0; i < 2; i++)
        begin
            tablePageReg = i ? 8'h92 : 8'h12;
            tableUpperSel = i;
            tableReadOp = 1;
            dataRead = 1;
            step();
            chk("taddr", {tablePageReg, 16'hb457}, progAddr);
            chk("cfg", i, configSpace);
            chk("upper", i, upperByteSel);
            tableWriteOp = 1;
            step();
            chk("wr", !i, progWriteEn);
            chk("rej", i, tableWriteReject);
        end
        dataRead = 1;
        step();
        chk("vaddr", {9'h05b, 15'h3456}, progAddr);
        chk("low", 1, visibilityLowWordOnly);
        coreControlReg = 16'h0000;
        dataRead = 1;
        step();
        chk("vis off", 0, progAddrValid);
        chk("low off", 0, visibilityLowWordOnly);
        fetchEn = 1;
        step();
        chk("fetch", 24'h2abcde, progAddr);
    endtask

    task automatic tally_and_finish;
        if (errCount == 0 && testsRun > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    initial
    begin
        rst_n = 0;
        {effectiveAddress, coreControlReg, stackLimitData} = '0;
        {stackPointerData, stackPushData, tablePageReg} = '0;
        {statusLowByte, tableUpperSel} = '0;
        visibilityPageReg = 8'h5b;
        programCounter = 23'h2abcdf;
        step();
        repeat (12) @(negedge clk);
        rst_n = 1;
        chk("rst sp", 16'h0800, stackPointer);
        t_stack();
        t_table();
        tally_and_finish();
    end

    initial
    begin
        repeat (1000) @(posedge clk);
        errCount++;
        tally_and_finish();
    end
endmodule

bind psa_prog_space_addr psa_chk u_psa_chk (.*);
